// File: design/psp_buffers.sv
// module: parallel slave port byte buffers, status flags and pad enables
// What this block does
// - pad-enable bits 15..14 hand the two top address pads to the port, else they are I/O.
// - each pad-enable bit 13..2 hands its address pad to the port, else it is I/O.
// - pad-enable bits 1..0 hand address pads 1 and 0 to the port, else they are I/O.
// - the input-all-full flag is 1 only while all four input buffers hold data.
// - a master write to a full input buffer sets a sticky overflow cleared by writing 0.
// - an input slot-full flag sets on master write and clears when software reads it.
// - the output-all-empty flag is 1 when all output buffers are empty, 1 at reset.
// - a master read from an empty output buffer sets a sticky underflow cleared by 0.
// - an output slot-empty flag is 1 at reset, clears on software write, sets on take.
// - in addressable mode the two low address lines pick buffer 0 to 3.
// - status bits 13, 12, 5 and 4 read zero and ignore writes.
// - port mode 01 selects the addressable slave mode using the two low address lines.
// - irq mode 11 raises an event on buffer 3 access, or address 11 in addressable mode.
`timescale 1ns/1ps
module psp_buffers
  import psp_pkg::*;
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic                 chip_select_one,
  input  wire logic                 read_strobe_pin,
  input  wire logic                 write_strobe_pin,
  input  wire logic [1:0]           port_address_lines,
  input  wire logic [7:0]           port_data_lines_in,
  output logic [7:0]                port_data_lines_out,
  output logic                      port_data_lines_oe,
  output logic [PAD_LINES-1:0]      pad_assign_bits,
  output logic                      input_threshold_select,
  output logic                      buffer_event
);
  import psp_pkg::*;

  typedef struct packed {
    logic                  ph_act;
    logic                  ph_wr;
    logic [7:0]            ph_ofs;
    logic [31:0]           rdata;
    logic [15:0]           pin_en;
    logic [1:0]            pad_cfg;
    logic [1:0]            port_mode;
    logic [1:0]            irq_mode;
    logic [NUM_SLOTS-1:0]  in_full;
    logic [NUM_SLOTS-1:0]  out_empty;
    logic                  in_ovf;
    logic                  out_unf;
    logic [31:0]           in_bytes;
    logic [31:0]           out_bytes;
    logic [7:0]            dout;
    logic                  evt;
    logic [15:0]           evt_cnt;
  } psp_core_s;

  psp_core_s     st_r;
  psp_core_s     st_nxt;
  psp_strobe_if  stb ();
  logic [15:0]   status_word;
  logic          addr_mode;
  logic          take_addr;

  // ---------------------------------------------------------------
  // pin front end
  // ---------------------------------------------------------------
  assign addr_mode = (st_r.port_mode == PORT_MODE_ADDR);

  psp_pin_sync u_sync (
    .hclk               (hclk),
    .hresetn            (hresetn),
    .addr_mode          (addr_mode),
    .chip_select_one    (chip_select_one),
    .read_strobe_pin    (read_strobe_pin),
    .write_strobe_pin   (write_strobe_pin),
    .port_address_lines (port_address_lines),
    .port_data_in       (port_data_lines_in),
    .stb                (stb.front)
  );

  // ---------------------------------------------------------------
  // status word
  // ---------------------------------------------------------------
  always_comb begin
    status_word = '0;
    status_word[ST_IN_ALL_FULL]   = &st_r.in_full;
    status_word[ST_IN_OVERFLOW]   = st_r.in_ovf;
    status_word[ST_IN_SLOT_LO +: NUM_SLOTS] = st_r.in_full;
    status_word[ST_OUT_ALL_EMPTY] = &st_r.out_empty;
    status_word[ST_OUT_UNDERFLOW] = st_r.out_unf;
    status_word[ST_OUT_SLOT_LO +: NUM_SLOTS] = st_r.out_empty;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [1:0] s;
    logic       wr_now;
    logic       rd_now;
    s         = stb.slot;
    wr_now    = 1'b0;
    rd_now    = 1'b0;
    take_addr = hsel & hready & htrans[1];
    st_nxt    = st_r;
    st_nxt.evt = 1'b0;

    // address phase capture
    if (hready) begin
      st_nxt.ph_act = take_addr;
      st_nxt.ph_wr  = hwrite;
      st_nxt.ph_ofs = haddr[7:0];
    end

    // read data prepared in the address phase, one wait-free data phase
    if (take_addr && !hwrite) begin
      unique case (haddr[7:0])
        OFS_PIN_ENABLE:   st_nxt.rdata = {16'h0000, st_r.pin_en};
        OFS_STATUS:       st_nxt.rdata = {16'h0000, status_word};
        OFS_PAD_CFG:      st_nxt.rdata = {30'h0, st_r.pad_cfg};
        OFS_OUT_WORD_ONE: st_nxt.rdata = {16'h0000, st_r.out_bytes[15:0]};
        OFS_OUT_WORD_TWO: st_nxt.rdata = {16'h0000, st_r.out_bytes[31:16]};
        OFS_IN_WORD_ONE:  st_nxt.rdata = {16'h0000, st_r.in_bytes[15:0]};
        OFS_IN_WORD_TWO:  st_nxt.rdata = {16'h0000, st_r.in_bytes[31:16]};
        OFS_MODE:         st_nxt.rdata = {16'h0000, 1'b0, st_r.irq_mode, 3'h0,
                                          st_r.port_mode, 8'h00};
        OFS_IRQ_COUNT:    st_nxt.rdata = {16'h0000, st_r.evt_cnt};
        default:          st_nxt.rdata = '0;
      endcase
      // software read of an input word empties its two slots
      if (haddr[7:0] == OFS_IN_WORD_ONE) begin
        st_nxt.in_full[1:0] = 2'b00;
      end
      if (haddr[7:0] == OFS_IN_WORD_TWO) begin
        st_nxt.in_full[3:2] = 2'b00;
      end
    end

    // register writes in the data phase
    if (st_r.ph_act && st_r.ph_wr) begin
      unique case (st_r.ph_ofs)
        OFS_PIN_ENABLE: st_nxt.pin_en = hwdata[15:0];
        OFS_STATUS: begin
          if (!hwdata[ST_IN_OVERFLOW]) begin
            st_nxt.in_ovf = 1'b0;
          end
          if (!hwdata[ST_OUT_UNDERFLOW]) begin
            st_nxt.out_unf = 1'b0;
          end
        end
        OFS_PAD_CFG: st_nxt.pad_cfg = hwdata[1:0] & PAD_CFG_MASK;
        OFS_OUT_WORD_ONE: begin
          st_nxt.out_bytes[15:0]  = hwdata[15:0];
          st_nxt.out_empty[1:0]   = 2'b00;
        end
        OFS_OUT_WORD_TWO: begin
          st_nxt.out_bytes[31:16] = hwdata[15:0];
          st_nxt.out_empty[3:2]   = 2'b00;
        end
        OFS_MODE: begin
          st_nxt.port_mode = hwdata[MD_MODE_LO +: 2];
          st_nxt.irq_mode  = hwdata[MD_IRQ_LO +: 2];
        end
        default: ;
      endcase
    end

    // master side events win over software clears
    if (stb.wr_evt) begin
      wr_now = 1'b1;
      if (st_r.in_full[s]) begin
        st_nxt.in_ovf = 1'b1;
      end else begin
        st_nxt.in_bytes[{s, 3'h0} +: 8] = stb.wdata;
      end
      st_nxt.in_full[s] = 1'b1;
    end
    if (stb.rd_evt) begin
      rd_now = 1'b1;
      st_nxt.dout = st_r.out_bytes[{s, 3'h0} +: 8];
      if (st_r.out_empty[s]) begin
        st_nxt.out_unf = 1'b1;
      end
      st_nxt.out_empty[s] = 1'b1;
    end

    // buffer event in irq mode 11
    if ((wr_now || rd_now) && st_r.irq_mode == IRQ_MODE_LAST && s == SLOT_LAST) begin
      st_nxt.evt     = 1'b1;
      st_nxt.evt_cnt = 16'(st_r.evt_cnt + 16'h0001);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r           <= '0;
      st_r.pin_en    <= PIN_ENABLE_RST;
      st_r.out_empty <= SLOT_EMPTY_RST;
      st_r.port_mode <= PORT_MODE_LEGACY;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hrdata                 = st_r.rdata;
  assign hreadyout              = 1'b1;
  assign hresp                  = 1'b0;
  assign port_data_lines_out    = st_r.dout;
  assign port_data_lines_oe     = stb.rd_active;
  assign input_threshold_select = st_r.pad_cfg[0];
  assign buffer_event           = st_r.evt;
  assign pad_assign_bits[15:14] = st_r.pin_en[15:14];
  assign pad_assign_bits[13:2]  = st_r.pin_en[13:2];
  assign pad_assign_bits[1:0]   = st_r.pin_en[1:0];

  logic unused_ok;
  assign unused_ok = &{1'b0, hsize};
endmodule // psp_buffers

// File: include/psp_pkg.sv
// package: register map, field positions and modes of the parallel slave port buffers
package psp_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFS_PIN_ENABLE   = 8'h00;
  localparam logic [7:0] OFS_STATUS       = 8'h04;
  localparam logic [7:0] OFS_PAD_CFG      = 8'h08;
  localparam logic [7:0] OFS_OUT_WORD_ONE = 8'h0c;
  localparam logic [7:0] OFS_OUT_WORD_TWO = 8'h10;
  localparam logic [7:0] OFS_IN_WORD_ONE  = 8'h14;
  localparam logic [7:0] OFS_IN_WORD_TWO  = 8'h18;
  localparam logic [7:0] OFS_MODE         = 8'h1c;
  localparam logic [7:0] OFS_IRQ_COUNT    = 8'h20;

  // status field positions
  localparam int ST_IN_ALL_FULL   = 15;
  localparam int ST_IN_OVERFLOW   = 14;
  localparam int ST_IN_SLOT_LO    = 8;
  localparam int ST_OUT_ALL_EMPTY = 7;
  localparam int ST_OUT_UNDERFLOW = 6;
  localparam int ST_OUT_SLOT_LO   = 0;

  // mode register fields
  localparam int MD_IRQ_LO  = 13;
  localparam int MD_MODE_LO = 8;

  localparam logic [1:0] PORT_MODE_LEGACY = 2'h0;
  localparam logic [1:0] PORT_MODE_ADDR   = 2'h1;
  localparam logic [1:0] IRQ_MODE_LAST    = 2'h3;
  localparam logic [1:0] SLOT_LAST        = 2'h3;

  localparam logic [15:0] PIN_ENABLE_RST  = 16'h0000;
  localparam logic [3:0]  SLOT_EMPTY_RST  = 4'hf;
  localparam logic [1:0]  PAD_CFG_MASK    = 2'h3;

  localparam int NUM_SLOTS = 4;
  localparam int PAD_LINES = 16;
endpackage

// File: include/psp_strobe_if.sv
// interface: synchronised strobe events from the pin front end to the buffer core
`timescale 1ns/1ps
interface psp_strobe_if;
  logic       rd_evt;
  logic       wr_evt;
  logic [1:0] slot;
  logic [7:0] wdata;
  logic       rd_active;
  modport front (output rd_evt, output wr_evt, output slot, output wdata, output rd_active);
  modport core  (input rd_evt, input wr_evt, input slot, input wdata, input rd_active);
endinterface

// File: design/psp_pin_sync.sv
// module: pin synchroniser and strobe edge detector for the slave port
`timescale 1ns/1ps
module psp_pin_sync
  import psp_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       addr_mode,
  input  wire logic       chip_select_one,
  input  wire logic       read_strobe_pin,
  input  wire logic       write_strobe_pin,
  input  wire logic [1:0] port_address_lines,
  input  wire logic [7:0] port_data_in,
  psp_strobe_if.front     stb
);
  typedef struct packed {
    logic [12:0] s1;
    logic [12:0] s2;
    logic        rd_q;
    logic        wr_q;
  } psp_sync_s;

  psp_sync_s st_r;
  psp_sync_s st_nxt;
  logic      rd_lvl;
  logic      wr_lvl;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = {chip_select_one, read_strobe_pin, write_strobe_pin,
                 port_address_lines, port_data_in};
    st_nxt.s2 = st_r.s1;
    rd_lvl    = st_r.s2[12] & st_r.s2[11];
    wr_lvl    = st_r.s2[12] & st_r.s2[10];
    st_nxt.rd_q = rd_lvl;
    st_nxt.wr_q = wr_lvl;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // master holds select lines stable through the strobe
  assign stb.rd_evt    = rd_lvl & ~st_r.rd_q;
  assign stb.wr_evt    = st_r.wr_q & ~wr_lvl;
  assign stb.slot      = addr_mode ? st_r.s2[9:8] : 2'h0;
  assign stb.wdata     = st_r.s2[7:0];
  assign stb.rd_active = rd_lvl;
endmodule // psp_pin_sync

// File: testbench/psp_buffers_sva.sv
// checker: bus, status and pad relations of the slave port buffers
`timescale 1ns/1ps
module psp_buffers_sva
  import psp_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        chip_select_one,
  input wire logic        read_strobe_pin,
  input wire logic        port_data_lines_oe,
  input wire logic [15:0] pad_assign_bits,
  input wire logic        input_threshold_select,
  input wire logic        buffer_event
);
  // ----------------------------------------------------------------
  // data phase markers
  // ----------------------------------------------------------------
  logic [2:0] dp_r;
  wire        acc = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) dp_r <= 3'h0;
    else dp_r <= {acc && hwrite && haddr == {24'h0, OFS_PIN_ENABLE},
                  acc && hwrite && haddr == {24'h0, OFS_PAD_CFG},
                  acc && !hwrite && haddr == {24'h0, OFS_STATUS}};
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ready_high_a: assert property (hreadyout) else $error("hreadyout low");
  resp_okay_a: assert property (!hresp) else $error("hresp not okay");
  pin_enable_a: assert property (
    dp_r[2] |=> pad_assign_bits == $past(hwdata[15:0]))
    else $error("pad enables differ from write");
  pad_cfg_a: assert property (dp_r[1] |=> input_threshold_select == $past(hwdata[0]))
    else $error("threshold select differs from write");
  status_rsvd_a: assert property (
    dp_r[0] |-> hrdata[13:12] == 2'h0 && hrdata[5:4] == 2'h0)
    else $error("reserved status bits set");
  in_full_sum_a: assert property (dp_r[0] |-> hrdata[15] == (&hrdata[11:8]))
    else $error("input full summary wrong");
  out_empty_sum_a: assert property (dp_r[0] |-> hrdata[7] == (&hrdata[3:0]))
    else $error("output empty summary wrong");
  oe_on_a: assert property (
    (chip_select_one && read_strobe_pin) [*5] |-> port_data_lines_oe)
    else $error("data lines not driven during read");
  oe_off_a: assert property ((!read_strobe_pin) [*5] |-> !port_data_lines_oe)
    else $error("data lines driven without read");
  event_pulse_a: assert property (buffer_event |=> !buffer_event)
    else $error("event longer than one cycle");
endmodule // psp_buffers_sva
bind psp_buffers psp_buffers_sva psp_buffers_sva_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .chip_select_one, .read_strobe_pin,
  .port_data_lines_oe, .pad_assign_bits, .input_threshold_select, .buffer_event);

// File: testbench/psp_master_model.sv
// partner: external parallel bus master driving the slave port pins
`timescale 1ns/1ps
module psp_master_model (
  input  wire logic       hclk,
  output logic            cs,
  output logic            rd,
  output logic            wr,
  output logic [1:0]      addr,
  output logic [7:0]      dout,
  input  wire logic [7:0] din
);
  initial begin
    cs = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 2'h0;
    dout = 8'h00;
  end
  // select and address settle before the strobe, held past its end
  task automatic sel(input logic [1:0] a);
    @(posedge hclk);
    cs <= 1'b1;
    addr <= a;
    repeat (2) @(posedge hclk);
  endtask
  task automatic unsel();
    repeat (4) @(posedge hclk);
    cs <= 1'b0;
    addr <= ~addr;
    dout <= ~dout;
  endtask
  task automatic wr_byte(input logic [1:0] a, input logic [7:0] d);
    sel(a);
    dout <= d;
    wr <= 1'b1;
    repeat (4) @(posedge hclk);
    wr <= 1'b0;
    unsel();
  endtask
  task automatic rd_byte(input logic [1:0] a, output logic [7:0] d);
    sel(a);
    rd <= 1'b1;
    repeat (7) @(posedge hclk);
    d = din;
    rd <= 1'b0;
    unsel();
  endtask
endmodule // psp_master_model

// File: testbench/psp_buffers_tb_top.sv
// testbench: register, buffer and pin scenarios of the slave port buffers
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module psp_buffers_tb_top;
  import psp_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, cs, rd, wr, oe, its, evt;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0]  htrans, pa;
  logic [2:0]  hsize;
  logic [7:0]  pdo, pdi, b;
  logic [15:0] pab;
  int          miscompares, checks_done, cycles, evt_n;
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  psp_buffers psp_buffers_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .chip_select_one(cs),
    .read_strobe_pin(rd), .write_strobe_pin(wr), .port_address_lines(pa),
    .port_data_lines_in(pdi), .port_data_lines_out(pdo), .port_data_lines_oe(oe),
    .pad_assign_bits(pab), .input_threshold_select(its), .buffer_event(evt));
  psp_master_model psp_master_model_i (.hclk(hclk), .cs(cs), .rd(rd), .wr(wr), .addr(pa),
    .dout(pdi), .din(pdo));
  always @(negedge hclk) begin
    cycles++;
    if (evt === 1'b1) evt_n++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    ahb(1'b0, a, 32'h0);
    `CHK(rdat, {16'h0, e})
  endtask
  task automatic t_reset();
    rd_chk(OFS_STATUS, 16'h008f);
    rd_chk(OFS_PIN_ENABLE, 16'h0000);
    ahb(1'b1, 8'h40, 32'h0000ffff);
    rd_chk(8'h40, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_pins();
    ahb(1'b1, OFS_PIN_ENABLE, 32'h0000c003);
    rd_chk(OFS_PIN_ENABLE, 16'hc003);
    `CHK(pab, 16'hc003)
    ahb(1'b1, OFS_PIN_ENABLE, 32'h00003ffc);
    rd_chk(OFS_PIN_ENABLE, 16'h3ffc);
    `CHK(pab, 16'h3ffc)
    ahb(1'b1, OFS_PAD_CFG, 32'h0000ffff);
    rd_chk(OFS_PAD_CFG, 16'h0003);
    `CHK(its, 1'b1)
    $display("test pins done");
  endtask
  task automatic t_input();
    int n;
    logic [3:0] m;
    n = evt_n;
    ahb(1'b1, OFS_MODE, 32'h00006100);
    rd_chk(OFS_MODE, 16'h6100);
    for (int k = 0; k < 4; k++) begin
      psp_master_model_i.wr_byte(2'(k), {4'(k), 4'ha});
      m = 4'((1 << (k + 1)) - 1);
      rd_chk(OFS_STATUS, {(k == 3), 3'h0, m, 8'h8f});
    end
    `CHK(evt_n - n, 1)
    rd_chk(OFS_IRQ_COUNT, 16'h0001);
    psp_master_model_i.wr_byte(2'h0, 8'hee);
    rd_chk(OFS_STATUS, 16'hcf8f);
    rd_chk(OFS_IN_WORD_ONE, 16'h1a0a);
    rd_chk(OFS_STATUS, 16'h4c8f);
    rd_chk(OFS_IN_WORD_TWO, 16'h3a2a);
    ahb(1'b1, OFS_STATUS, 32'h0000ffff);
    rd_chk(OFS_STATUS, 16'h408f);
    ahb(1'b1, OFS_STATUS, 32'h0);
    rd_chk(OFS_STATUS, 16'h008f);
    $display("test input done");
  endtask
  task automatic t_output();
    int n;
    logic [3:0] m;
    logic [7:0] ob [4] = '{8'hb2, 8'ha1, 8'hd4, 8'hc3};
    n = evt_n;
    ahb(1'b1, OFS_OUT_WORD_ONE, 32'h0000a1b2);
    ahb(1'b1, OFS_OUT_WORD_TWO, 32'h0000c3d4);
    rd_chk(OFS_OUT_WORD_ONE, 16'ha1b2);
    rd_chk(OFS_OUT_WORD_TWO, 16'hc3d4);
    rd_chk(OFS_STATUS, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      psp_master_model_i.rd_byte(2'(k), b);
      `CHK(b, ob[k])
      m = 4'((1 << (k + 1)) - 1);
      rd_chk(OFS_STATUS, {8'h00, (k == 3), 3'h0, m});
    end
    `CHK(evt_n - n, 1)
    rd_chk(OFS_IRQ_COUNT, 16'h0002);
    psp_master_model_i.rd_byte(2'h1, b);
    rd_chk(OFS_STATUS, 16'h00cf);
    ahb(1'b1, OFS_STATUS, 32'h0);
    rd_chk(OFS_STATUS, 16'h008f);
    $display("test output done");
  endtask
  task automatic t_legacy();
    ahb(1'b1, OFS_MODE, 32'h0);
    psp_master_model_i.wr_byte(2'h3, 8'h5c);
    rd_chk(OFS_STATUS, 16'h018f);
    rd_chk(OFS_IN_WORD_ONE, 16'h1a5c);
    rd_chk(OFS_IRQ_COUNT, 16'h0002);
    `CHK(oe, 1'b0)
    $display("test legacy done");
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_pins();
    t_input();
    t_output();
    t_legacy();
    summarize();
  end
endmodule // psp_buffers_tb_top
